//--- accel_mode_and_output_control_bench.sv
// self-checking bench for the accelerometer control block
`timescale 1ns/1ps
module accel_mode_and_output_control_bench;
  import amc_pkg::*;
  localparam int                 WAKE  = 20;
  localparam int                 SLEEP = 40;
  localparam logic [6:0]         ADDR  = 7'h2a;  // arbitrary
  localparam logic signed [11:0] STC   = 12'sh030;
  localparam int                 LIMIT = 40000;

  logic        core_clk;
  logic        rst_n;
  logic        scl_out;
  logic        scl_oe_n;
  logic        sda_out;
  logic        sda_oe_n;
  logic        active_bit;
  logic        sleep_req;
  logic        fast_read;
  amc_range_t  range_sel;
  logic        self_test;
  amc_raw_t    accel [3];
  amc_sample_t out_d [3];
  logic        sample_done;
  logic        analog_en;
  amc_mode_t   mode_state;
  logic        scl_drv;
  logic        sda_drv;
  wire         scl_w;
  wire         sda_w;
  logic [9:0]  exp_out [3];
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  // pulled-up open-drain lines
  assign scl_w = scl_drv & (scl_oe_n ? 1'b1 : scl_out);
  assign sda_w = sda_drv & (sda_oe_n ? 1'b1 : sda_out);

  amc_accel_ctrl #(.WAKE_CYC(32'(WAKE)), .SLEEP_CYC(32'(SLEEP)), .DEV_ADDR(ADDR), .ST_COUNTS(STC)) dut_u (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .scl_in      (scl_w),
    .scl_out     (scl_out),
    .scl_oe_n    (scl_oe_n),
    .sda_in      (sda_w),
    .sda_out     (sda_out),
    .sda_oe_n    (sda_oe_n),
    .active_bit  (active_bit),
    .sleep_req   (sleep_req),
    .fast_read   (fast_read),
    .range_sel   (range_sel),
    .self_test   (self_test),
    .accel_in    (accel),
    .out_data    (out_d),
    .sample_done (sample_done),
    .analog_en   (analog_en),
    .mode_state  (mode_state)
  );

  amc_host_model #(.HB(40)) host_u (
    .core_clk (core_clk),
    .scl_drv  (scl_drv),
    .sda_drv  (sda_drv),
    .sda_line (sda_w)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  function automatic logic [9:0] scale(input amc_raw_t a, input logic st, input int s);
    logic signed [12:0] v;
    v = (13'(a) + (st ? 13'(STC) : 13'sh0000)) >>> s;
    if (v > 13'sh01ff)
      return 10'h1ff;
    if (v < -13'sh0200)
      return 10'h200;
    return v[9:0];
  endfunction

  function automatic logic [7:0] exp_byte(input int p);
    return p[0] ? {exp_out[p / 2][1:0], 6'h00} : exp_out[p / 2][9:2];
  endfunction

  task automatic wait_done(input int lim);
    int n;
    n = 0;
    while (sample_done !== 1'b1 && n < lim)
    begin
      tick(1);
      n++;
    end
    chk(16'(sample_done), 16'h1);
  endtask

  task automatic chk_out();
    for (int i = 0; i < 3; i++)
      chk({6'h00, out_d[i]}, {6'h00, exp_out[i]});
  endtask

  task automatic t_sample(input amc_range_t r, input logic st);
    active_bit = 1'b0;
    tick(2);
    range_sel  = r;
    self_test  = st;
    active_bit = 1'b1;
    tick(1);
    chk(16'(mode_state), 16'(M_WAKE));
    chk(16'(analog_en), 16'h1);
    chk({6'h00, out_d[0]}, 16'h0);
    for (int i = 0; i < 3; i++)
      exp_out[i] = scale(accel[i], st, int'(r));
    wait_done(WAKE + 5);
    chk_out();
    $display("done: sample range %0d selftest %0d", r, st);
  endtask

  task automatic t_sleep();
    sleep_req = 1'b1;
    tick(2);
    chk(16'(mode_state), 16'(M_SLEEP));
    chk(16'(analog_en), 16'h1);
    wait_done(SLEEP + 5);
    chk_out();
    sleep_req = 1'b0;
    tick(2);
    $display("done: sleep");
  endtask

  task automatic t_standby();
    int n;
    n = 0;
    active_bit = 1'b0;
    tick(2);
    chk(16'(mode_state), 16'(M_STBY));
    chk(16'(analog_en), 16'h0);
    repeat (3 * WAKE)
    begin
      tick(1);
      n += int'(sample_done === 1'b1);
    end
    chk(16'(n), 16'h0);
    chk_out();
    $display("done: standby");
  endtask

  // device stays in standby here, so the bus must still answer
  task automatic t_bus();
    logic [7:0] rx;
    logic       ack;
    // a foreign address must be left unanswered
    host_u.start_c();
    host_u.byte_c({ADDR ^ 7'h01, 1'b0}, 1'b1, rx, ack);
    chk(16'(ack), 16'h1);
    host_u.stop_c();
    for (int f = 0; f < 2; f++)
    begin
      fast_read = f[0];
      host_u.glitch_en = (f == 0);
      host_u.start_c();
      host_u.byte_c({ADDR, 1'b0}, 1'b1, rx, ack);
      chk(16'(ack), 16'h0);
      host_u.glitch_en = 1'b0;
      host_u.byte_c(8'h00, 1'b1, rx, ack);
      chk(16'(ack), 16'h0);
      host_u.start_c();
      host_u.byte_c({ADDR, 1'b1}, 1'b1, rx, ack);
      chk(16'(ack), 16'h0);
      for (int i = 0; i < 6 - 3 * f; i++)
      begin
        host_u.byte_c(8'hff, i == 5 - 3 * f, rx, ack);
        chk(16'(rx), 16'(exp_byte(f ? 2 * i : i)));
      end
      host_u.stop_c();
    end
    fast_read = 1'b0;
    $display("done: bus reads");
  endtask

  // watch the clock line and cut a hang short
  always @(negedge core_clk)
  begin
    cyc++;
    if (rst_n === 1'b1)
      chk(16'(scl_oe_n), 16'h1);
    if (cyc == LIMIT)
    begin
      fail_count++;
      end_sim();
    end
  end

  initial
  begin
    rst_n      = 1'b0;
    active_bit = 1'b0;
    sleep_req  = 1'b0;
    fast_read  = 1'b0;
    range_sel  = AMC_RANGE_2G;
    self_test  = 1'b0;
    accel[0]   = 12'sh7f0;
    accel[1]   = -12'sh2c5;
    accel[2]   = 12'sh0fb;
    tick(6);
    chk(16'(mode_state), 16'(M_STBY));
    chk(16'(sda_oe_n), 16'h1);
    chk(16'({scl_out, sda_out}), 16'h0);
    rst_n = 1'b1;
    tick(2);
    chk({6'h00, out_d[2]}, 16'h0);
    chk(16'(analog_en), 16'h0);
    $display("done: reset");
    t_sample(AMC_RANGE_2G, 1'b0);
    t_sample(AMC_RANGE_4G, 1'b0);
    t_sample(AMC_RANGE_8G, 1'b0);
    // zero and one g, so the encoding and self-test checks in the design see their cases
    accel[0]   = 12'sh000;
    accel[1]   = 12'sh100;
    accel[2]   = 12'sh100;
    t_sample(AMC_RANGE_4G, 1'b0);
    t_sample(AMC_RANGE_2G, 1'b1);
    t_sample(AMC_RANGE_4G, 1'b1);
    t_sleep();
    t_standby();
    t_bus();
    end_sim();
  end
endmodule

//--- amc_accel_ctrl.sv
// accelerometer mode control, output scaling and bus slave readout
// How it works
// - slave never pulls the clock line low
// - bus inputs ignore spikes up to 50 ns
// - counts per g follow selected range
// - results are two's complement from offset zero
// - self-test adds range-scaled stimulus per axis
// - reported value is acceleration plus stimulus
// - standby stops sampling, bus stays usable
// - active bit set runs sampling path
// - entering active clears output registers
// - sleep and wake both keep sampling
// - ten-bit result, high byte holds top eight
`timescale 1ns/1ps
`include "amc_defs.svh"
module amc_accel_ctrl #(
  parameter logic [31:0]     WAKE_CYC  = 32'(`AMC_WAKE_CYC),
  parameter logic [31:0]     SLEEP_CYC = 32'(`AMC_SLEEP_CYC),
  parameter logic [6:0]      DEV_ADDR  = `AMC_DEV_ADDR,
  parameter logic signed [11:0] ST_COUNTS = `AMC_ST_COUNTS
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  scl_in,
  output logic                       scl_out,
  output logic                       scl_oe_n,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe_n,
  input  wire logic                  active_bit,
  input  wire logic                  sleep_req,
  input  wire logic                  fast_read,
  input  amc_pkg::amc_range_t        range_sel,
  input  wire logic                  self_test,
  input  amc_pkg::amc_raw_t          accel_in [3],
  output amc_pkg::amc_sample_t       out_data [3],
  output logic                       sample_done,
  output logic                       analog_en,
  output amc_pkg::amc_mode_t         mode_state
);
  import amc_pkg::*;

  amc_pin_if scl_if ();
  amc_pin_if sda_if ();

  amc_mode_t   mode_reg;
  amc_mode_t   mode_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic [31:0] period;
  amc_sample_t out_reg [3];
  amc_sample_t out_next [3];
  amc_sample_t conv_val [3];
  logic        done_reg;
  logic        done_next;
  logic        entry;
  logic        tick;

  amc_i2c_t    ist_reg;
  amc_i2c_t    ist_next;
  logic [3:0]  bit_reg;
  logic [3:0]  bit_next;
  logic [7:0]  sh_reg;
  logic [7:0]  sh_next;
  logic [7:0]  ptr_reg;
  logic [7:0]  ptr_next;
  logic        rw_reg;
  logic        rw_next;
  logic        gotp_reg;
  logic        gotp_next;
  logic        drv_reg;
  logic        drv_next;
  logic        nack_reg;
  logic        nack_next;
  logic        scl_q;
  logic        sda_q;
  logic        scl_f;
  logic        sda_f;
  logic        scl_rise;
  logic        scl_fall;
  logic        start;
  logic        stop;
  logic [7:0]  rd_byte;
  logic [7:0]  ptr_adv;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  assign scl_if.raw = scl_in;
  assign sda_if.raw = sda_in;

  amc_glitch_filter u_scl_filt (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin      (scl_if.filt)
  );

  amc_glitch_filter u_sda_filt (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin      (sda_if.filt)
  );

  // input in 1/256 g; range shift sets counts per g, stimulus joins before the shift
  function automatic amc_sample_t conv(input amc_raw_t acc, input logic st_en, input amc_range_t rng);
    logic signed [12:0] sum;
    logic signed [12:0] scaled;
    sum    = {acc[11], acc} + (st_en ? {ST_COUNTS[11], ST_COUNTS} : 13'sh0000);
    scaled = sum;
    if (rng == AMC_RANGE_4G)
      scaled = sum >>> 1;
    else if (rng != AMC_RANGE_2G)
      scaled = sum >>> 2;
    if (scaled > `AMC_SAT_POS)
      conv = 10'sh1ff;
    else if (scaled < `AMC_SAT_NEG)
      conv = 10'sh200;
    else
      conv = scaled[9:0];
  endfunction

  for (genvar a = 0; a < 3; a++)
  begin : g_axis
    assign conv_val[a] = conv(accel_in[a], self_test, range_sel);
    assign out_data[a] = out_reg[a];
  end

  // operating mode; sleep is a sub-state of active
  always_comb
  begin
    mode_next = mode_reg;
    case (mode_reg)
      M_STBY:  if (active_bit) mode_next = M_WAKE;
      M_WAKE:
      begin
        if (!active_bit)
          mode_next = M_STBY;
        else if (sleep_req)
          mode_next = M_SLEEP;
      end
      M_SLEEP:
      begin
        if (!active_bit)
          mode_next = M_STBY;
        else if (!sleep_req)
          mode_next = M_WAKE;
      end
      default: mode_next = M_STBY;
    endcase
  end

  assign entry  = (mode_reg == M_STBY) && active_bit;
  assign period = (mode_reg == M_SLEEP) ? SLEEP_CYC : WAKE_CYC;
  assign tick   = (mode_reg != M_STBY) && (cnt_reg >= period - 32'h1);

  // sample clock is held at zero in standby instead of gated, same effect on results
  always_comb
  begin
    cnt_next  = cnt_reg;
    out_next  = out_reg;
    done_next = 1'b0;
    if (mode_reg == M_STBY)
    begin
      cnt_next = 32'h0;
      if (entry)
        out_next = '{default: `AMC_OUT_RST};
    end
    else if (tick)
    begin
      cnt_next  = 32'h0;
      out_next  = conv_val;
      done_next = 1'b1;
    end
    else
      cnt_next = cnt_reg + 32'h1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= M_STBY;
      cnt_reg  <= 32'h0;
      out_reg  <= '{default: `AMC_OUT_RST};
      done_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      cnt_reg  <= cnt_next;
      out_reg  <= out_next;
      done_reg <= done_next;
    end
  end

  assign sample_done = done_reg;
  assign analog_en   = (mode_reg != M_STBY);
  assign mode_state  = mode_reg;

  // bus slave: read-only view of results, written pointer selects the first byte
  assign scl_f    = scl_if.clean;
  assign sda_f    = sda_if.clean;
  assign scl_rise = scl_f && !scl_q;
  assign scl_fall = !scl_f && scl_q;
  assign start    = scl_f && scl_q && sda_q && !sda_f;
  assign stop     = scl_f && scl_q && !sda_q && sda_f;

  always_comb
  begin
    if (ptr_reg == `AMC_OUT_X_MSB)
      rd_byte = out_reg[0][`AMC_MSB_HI_POS:`AMC_MSB_LO_POS];
    else if (ptr_reg == `AMC_OUT_X_LSB)
      rd_byte = {out_reg[0][`AMC_LSB_BITS-1:0], 6'h00};
    else if (ptr_reg == `AMC_OUT_Y_MSB)
      rd_byte = out_reg[1][`AMC_MSB_HI_POS:`AMC_MSB_LO_POS];
    else if (ptr_reg == `AMC_OUT_Y_LSB)
      rd_byte = {out_reg[1][`AMC_LSB_BITS-1:0], 6'h00};
    else if (ptr_reg == `AMC_OUT_Z_MSB)
      rd_byte = out_reg[2][`AMC_MSB_HI_POS:`AMC_MSB_LO_POS];
    else if (ptr_reg == `AMC_OUT_Z_LSB)
      rd_byte = {out_reg[2][`AMC_LSB_BITS-1:0], 6'h00};
    else
      rd_byte = 8'h00;
  end

  // from an even pointer, fast read walks the high bytes only and wraps back to the first axis
  always_comb
  begin
    if (fast_read)
      ptr_adv = (ptr_reg >= `AMC_OUT_Z_MSB) ? `AMC_OUT_X_MSB : 8'(ptr_reg + 8'h02);
    else
      ptr_adv = (ptr_reg >= `AMC_OUT_Z_LSB) ? `AMC_OUT_X_MSB : 8'(ptr_reg + 8'h01);
  end

  always_comb
  begin
    ist_next  = ist_reg;
    bit_next  = bit_reg;
    sh_next   = sh_reg;
    ptr_next  = ptr_reg;
    rw_next   = rw_reg;
    gotp_next = gotp_reg;
    drv_next  = drv_reg;
    nack_next = nack_reg;
    if (stop)
    begin
      ist_next = I_IDLE;
      drv_next = 1'b0;
    end
    else if (start)
    begin
      ist_next  = I_DEVADR;
      bit_next  = 4'h0;
      drv_next  = 1'b0;
      gotp_next = 1'b0;
    end
    else
    begin
      case (ist_reg)
        I_DEVADR, I_REGADR:
        begin
          if (scl_rise && bit_reg < 4'h8)
          begin
            sh_next  = {sh_reg[6:0], sda_f};
            bit_next = 4'(bit_reg + 4'h1);
          end
          else if (scl_fall && bit_reg == 4'h8)
          begin
            if (ist_reg == I_DEVADR)
            begin
              if (sh_reg[7:1] == DEV_ADDR)
              begin
                rw_next  = sh_reg[0];
                drv_next = 1'b1;
                ist_next = I_ACK;
              end
              else
                ist_next = I_IDLE;
            end
            else
            begin
              // later write bytes are acknowledged and dropped; no writable register here
              if (!gotp_reg)
              begin
                ptr_next  = sh_reg;
                gotp_next = 1'b1;
              end
              drv_next = 1'b1;
              ist_next = I_ACK;
            end
          end
        end
        I_ACK:
        begin
          if (scl_fall)
          begin
            bit_next = 4'h0;
            if (rw_reg)
            begin
              sh_next  = rd_byte;
              ptr_next = ptr_adv;
              drv_next = !rd_byte[7];
              ist_next = I_TX;
            end
            else
            begin
              drv_next = 1'b0;
              ist_next = I_REGADR;
            end
          end
        end
        I_TX:
        begin
          if (scl_fall)
          begin
            if (bit_reg == 4'h7)
            begin
              drv_next = 1'b0;
              ist_next = I_MACK;
            end
            else
            begin
              sh_next  = {sh_reg[6:0], 1'b0};
              drv_next = !sh_reg[6];
              bit_next = 4'(bit_reg + 4'h1);
            end
          end
        end
        I_MACK:
        begin
          if (scl_rise)
            nack_next = sda_f;
          else if (scl_fall)
          begin
            if (nack_reg)
              ist_next = I_IDLE;
            else
            begin
              bit_next = 4'h0;
              sh_next  = rd_byte;
              ptr_next = ptr_adv;
              drv_next = !rd_byte[7];
              ist_next = I_TX;
            end
          end
        end
        default: ist_next = I_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ist_reg  <= I_IDLE;
      bit_reg  <= 4'h0;
      sh_reg   <= 8'h00;
      ptr_reg  <= `AMC_OUT_X_MSB;
      rw_reg   <= 1'b0;
      gotp_reg <= 1'b0;
      drv_reg  <= 1'b0;
      nack_reg <= 1'b0;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end
    else
    begin
      ist_reg  <= ist_next;
      bit_reg  <= bit_next;
      sh_reg   <= sh_next;
      ptr_reg  <= ptr_next;
      rw_reg   <= rw_next;
      gotp_reg <= gotp_next;
      drv_reg  <= drv_next;
      nack_reg <= nack_next;
      scl_q    <= scl_f;
      sda_q    <= sda_f;
    end
  end

  // clock line is never driven: no stretching
  assign scl_out  = 1'b0;
  assign scl_oe_n = 1'b1;
  assign sda_out  = 1'b0;
  assign sda_oe_n = !drv_reg;

  scl_release_a: assert property (scl_oe_n && !(sda_oe_n == 1'b0 && ist_reg == I_IDLE))
    else $error("clock line driven or data held while idle");
  stby_no_sample_a: assert property ((mode_reg == M_STBY) |=> !sample_done)
    else $error("sample produced in standby");
  active_runs_a: assert property ((mode_reg == M_WAKE && cnt_reg == WAKE_CYC - 32'h1 && active_bit)
    |=> sample_done)
    else $error("no sample at the end of the wake period");
  entry_clear_a: assert property ((mode_reg == M_STBY && active_bit)
    |=> (out_reg[0] == `AMC_OUT_RST && out_reg[1] == `AMC_OUT_RST && out_reg[2] == `AMC_OUT_RST))
    else $error("outputs not cleared on entering active");
  sleep_sample_a: assert property ((mode_reg == M_SLEEP && cnt_reg == SLEEP_CYC - 32'h1 && active_bit)
    |=> sample_done)
    else $error("sleep stopped sampling");
  zero_mid_a: assert property ((tick && !self_test && accel_in[0] == 12'sh000)
    |=> out_reg[0] == 10'sh000)
    else $error("zero acceleration not encoded as zero");
  scale_4g_a: assert property ((tick && !self_test && range_sel == AMC_RANGE_4G
    && accel_in[1] == 12'sh100) |=> out_reg[1] == 10'sh080)
    else $error("one g does not give 128 counts in the 4 g range");
  selftest_sum_a: assert property ((tick && self_test && range_sel == AMC_RANGE_2G
    && accel_in[2] == 12'sh100) |=> out_reg[2] == 10'(12'sh100 + ST_COUNTS))
    else $error("self-test output is not acceleration plus stimulus");
  fast_even_a: assert property ((ist_reg == I_MACK && scl_fall && !nack_reg && fast_read
    && ptr_reg[0] == 1'b0) |=> ptr_reg[0] == 1'b0)
    else $error("fast read stepped onto a low byte");

  cover property (mode_reg == M_STBY && active_bit);
  cover property (ist_reg == I_TX && scl_fall && bit_reg == 4'h7);
  cover property (tick && self_test);
  cover property (mode_reg == M_SLEEP && sample_done);
endmodule

//--- amc_defs.svh
// shared offsets, field positions, reset values and timing counts
`ifndef AMC_DEFS_SVH
`define AMC_DEFS_SVH

`define AMC_CLK_NS        4
`define AMC_CLK_HZ        64'd250000000
`define AMC_SPIKE_NS      50
// one sample more than the widest spike, so a full-width spike never passes
`define AMC_SPIKE_CYC     ((`AMC_SPIKE_NS + `AMC_CLK_NS - 1) / `AMC_CLK_NS + 1)
`define AMC_WAKE_ODR_HZ   64'd800
`define AMC_WAKE_CYC      (`AMC_CLK_HZ / `AMC_WAKE_ODR_HZ)
`define AMC_SLEEP_ODR_MHZ 64'd1563
`define AMC_SLEEP_CYC     ((`AMC_CLK_HZ * 64'd1000) / `AMC_SLEEP_ODR_MHZ)

`define AMC_OUT_X_MSB     8'h00
`define AMC_OUT_X_LSB     8'h01
`define AMC_OUT_Y_MSB     8'h02
`define AMC_OUT_Y_LSB     8'h03
`define AMC_OUT_Z_MSB     8'h04
`define AMC_OUT_Z_LSB     8'h05
`define AMC_MSB_HI_POS    9
`define AMC_MSB_LO_POS    2
`define AMC_LSB_BITS      2
`define AMC_OUT_RST       10'h000
`define AMC_SAT_POS       13'sh01ff
`define AMC_SAT_NEG       -13'sh0200
// arbitrary bus address, not tied to any product
`define AMC_DEV_ADDR      7'h3c
`define AMC_ST_COUNTS     12'sh040

`endif

//--- amc_glitch_filter.sv
// synchroniser and spike filter for one bus input
`timescale 1ns/1ps
`include "amc_defs.svh"
module amc_glitch_filter #(
  parameter int FILT_CYC = `AMC_SPIKE_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  amc_pin_if.filt  pin
);
  import amc_pkg::*;

  localparam int CW = $clog2(FILT_CYC + 1);
  logic [2:0]    sync_reg;
  logic [2:0]    sync_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          clean_reg;
  logic          clean_next;

  // bus idles high, so reset to the released level
  always_comb
  begin
    sync_next  = {sync_reg[1:0], pin.raw};
    cnt_next   = '0;
    clean_next = clean_reg;
    if (sync_reg[1] == sync_reg[2] && sync_reg[2] != clean_reg)
    begin
      if (cnt_reg == CW'(FILT_CYC - 1))
        clean_next = sync_reg[2];
      else
        cnt_next = CW'(cnt_reg + 1'b1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_reg  <= 3'h7;
      cnt_reg   <= '0;
      clean_reg <= 1'b1;
    end
    else
    begin
      sync_reg  <= sync_next;
      cnt_reg   <= cnt_next;
      clean_reg <= clean_next;
    end
  end

  assign pin.clean = clean_reg;

  spike_block_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clean_reg != $past(clean_reg)) |-> ($past(cnt_reg) == CW'(FILT_CYC - 1)))
    else $error("filtered line changed before the spike window elapsed");
  cover property (@(posedge core_clk) disable iff (!rst_n) $fell(clean_reg));
endmodule

//--- amc_host_model.sv
// behavioural bus master standing in for the host processor
`timescale 1ns/1ps
module amc_host_model #(
  parameter int HB = 40
) (
  input  wire logic core_clk,
  output logic      scl_drv,
  output logic      sda_drv,
  input  wire logic sda_line
);
  logic glitch_en;

  initial
  begin
    scl_drv   = 1'b1;
    sda_drv   = 1'b1;
    glitch_en = 1'b0;
  end

  task automatic wait_c(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // also a repeated start: scl is low on entry then
  task automatic start_c();
    sda_drv = 1'b1;
    wait_c(HB);
    scl_drv = 1'b1;
    wait_c(HB);
    sda_drv = 1'b0;
    wait_c(HB);
    scl_drv = 1'b0;
    wait_c(HB / 2);
  endtask

  task automatic stop_c();
    sda_drv = 1'b0;
    wait_c(HB);
    scl_drv = 1'b1;
    wait_c(HB);
    sda_drv = 1'b1;
    wait_c(HB);
  endtask

  // data moves only mid low phase, never next to an scl edge
  task automatic bit_c(input logic b, input logic glitch, output logic r);
    sda_drv = b;
    wait_c(HB);
    scl_drv = 1'b1;
    wait_c(HB / 2);
    r = sda_line;
    if (glitch)
    begin
      scl_drv = 1'b0;
      #48;
      scl_drv = 1'b1;
    end
    wait_c(HB / 2);
    scl_drv = 1'b0;
    wait_c(HB / 2);
  endtask

  // last = 1 releases sda for the slave ack, or sends nack on reads
  task automatic byte_c(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_c(tx[i], glitch_en && i == 3, rx[i]);
    bit_c(last, 1'b0, ack);
  endtask
endmodule

//--- amc_pin_if.sv
// one bus line between the pin filter and the controller
`timescale 1ns/1ps
interface amc_pin_if;
  logic raw;
  logic clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface

//--- amc_pkg.sv
// types shared by the accelerometer control block
package amc_pkg;
  typedef enum logic [1:0] {AMC_RANGE_2G = 2'h0, AMC_RANGE_4G = 2'h1, AMC_RANGE_8G = 2'h2} amc_range_t;
  typedef enum logic [2:0] {M_STBY = 3'h1, M_WAKE = 3'h2, M_SLEEP = 3'h4} amc_mode_t;
  typedef enum logic [5:0] {I_IDLE = 6'h01, I_DEVADR = 6'h02, I_REGADR = 6'h04,
                            I_ACK = 6'h08, I_TX = 6'h10, I_MACK = 6'h20} amc_i2c_t;
  typedef logic signed [11:0] amc_raw_t;
  typedef logic signed [9:0]  amc_sample_t;
endpackage
